// File: src/dag_core.sv
// Data address generator: address arithmetic, alignment, write-back, load extension
// Operation
// - 32-bit byte addresses; byte, halfword and word accesses supported.
// - No size selected means a word access.
// - Halfword and byte loads extend to 32 bits, signed unless unsigned chosen.
// - Memory sees aligned address: word drops two LSBs, halfword drops one.
// - Address register write-back takes the full unaligned generated address.
// - Scaling shifts index left by two, one or zero bits per size.
// - For bytes the scale bit becomes an extra immediate offset bit.
// - Scaled immediates always give offsets that are multiples of access size.
// - All twelve modes may use local data or parameter RAM base.
// - Local base only for single transfer or local with non-field move.
// - Local-relative generated address may be written into an address register.
// - Second local data RAM at 0x800, third at 0x8000 from RAM zero.
// - Pre or post indexing by add or subtract; post always updates register.
`timescale 1ns/1ns
`include "dag_regs.svh"
module dag_core #(
    parameter int ADDR_W = `DAG_ADDR_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Processor base addresses
    input wire logic [ADDR_W-1:0] data_ram_base_i,
    input wire logic [ADDR_W-1:0] param_ram_base_i,
    // Address request
    input wire logic req_valid_i,
    input wire dag_pkg::dag_req_s req_i,
    // Load data return
    input wire logic load_valid_i,
    input wire logic [31:0] load_data_i,
    // Generated address
    output logic addr_valid_o,
    output dag_pkg::dag_addr_s addr_o,
    output logic [ADDR_W-1:0] ram_one_base_o,
    output logic [ADDR_W-1:0] ram_two_base_o,
    output logic base_illegal_o,
    // Extended load data
    output logic ext_valid_o,
    output logic [31:0] ext_data_o
);
    dag_pkg::dag_req_s r;
    assign r = req_i;

    wire dag_pkg::dag_size_e size_w = dag_pkg::dag_size_e'(r.size_sel ? r.size :
                                                           dag_pkg::DAG_SIZE_WORD);
    wire is_byte = (size_w == dag_pkg::DAG_SIZE_BYTE);
    wire is_half = (size_w == dag_pkg::DAG_SIZE_HALF);

    wire [15:0] short_imm = is_byte ? {12'h000, r.scale, r.imm[`DAG_SHORT_W-1:0]} :
                                      {13'h0000, r.imm[`DAG_SHORT_W-1:0]};
    wire [15:0] long_imm = is_byte ? {r.scale, r.imm[`DAG_LONG_W-1:0]} :
                                     {1'b0, r.imm[`DAG_LONG_W-1:0]};
    wire [15:0] imm_w = r.long_imm ? long_imm : short_imm;
    wire [31:0] raw_idx = r.use_imm ? {16'h0000, imm_w} : r.index_reg;
    // Scale bit has no shift meaning for bytes
    wire do_scale = r.scale & ~is_byte;

    wire [1:0] shamt = ~do_scale ? 2'(`DAG_BYTE_SHIFT) :
                       is_half ? 2'(`DAG_HALF_SHIFT) : 2'(`DAG_WORD_SHIFT);
    wire [31:0] idx_w = raw_idx << shamt;

    wire [31:0] base_w = (r.base == dag_pkg::DAG_BASE_DATA) ? data_ram_base_i :
                         (r.base == dag_pkg::DAG_BASE_PARAM) ? param_ram_base_i : r.reg_base;

    wire local_base = (r.base != dag_pkg::DAG_BASE_REG);
    wire xfer_ok = (r.xfer == dag_pkg::DAG_XFER_SINGLE) ||
                   (r.xfer == dag_pkg::DAG_XFER_LOCAL_MOVE);
    wire illegal_w = local_base & ~xfer_ok;

    wire [31:0] gen_w = r.subtract ? 32'(base_w - idx_w) : 32'(base_w + idx_w);

    wire [31:0] out_w = r.post ? base_w : gen_w;
    wire wb_w = r.post | r.modify;

    wire [31:0] mask_w = is_byte ? 32'hFFFF_FFFF : is_half ? 32'hFFFF_FFFE : 32'hFFFF_FFFC;
    wire [3:0] be_w = is_byte ? (4'h1 << out_w[1:0]) :
                      is_half ? (out_w[1] ? 4'hC : 4'h3) : 4'hF;

    logic addr_valid_q;
    dag_pkg::dag_addr_s addr_q;
    logic illegal_q;
    logic [1:0] lane_q;
    dag_pkg::dag_size_e size_q;
    logic uns_q;
    logic ext_valid_q;
    logic [31:0] ext_q;
    logic [31:0] ext_w;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            addr_valid_q <= 1'b0;
            addr_q <= '0;
            illegal_q <= 1'b0;
            lane_q <= 2'h0;
            size_q <= dag_pkg::DAG_SIZE_WORD;
            uns_q <= 1'b0;
        end else begin
            addr_valid_q <= req_valid_i & ~illegal_w;
            illegal_q <= req_valid_i & illegal_w;
            if (req_valid_i & ~illegal_w) begin
                addr_q.mem_addr <= out_w & mask_w;
                addr_q.wb_addr <= gen_w;
                addr_q.wb_en <= wb_w;
                addr_q.byte_en <= be_w;
                lane_q <= out_w[1:0];
                size_q <= size_w;
                uns_q <= r.unsigned_ld;
            end
        end
    end

    dag_extend u_extend (
        .raw_i(load_data_i),
        .lane_i(lane_q),
        .size_i(size_q),
        .unsigned_i(uns_q),
        .ext_o(ext_w)
    );

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ext_valid_q <= 1'b0;
            ext_q <= 32'h0000_0000;
        end else begin
            ext_valid_q <= load_valid_i;
            if (load_valid_i) begin
                ext_q <= ext_w;
            end
        end
    end

    assign addr_valid_o = addr_valid_q;
    assign addr_o = addr_q;
    assign base_illegal_o = illegal_q;
    assign ext_valid_o = ext_valid_q;
    assign ext_data_o = ext_q;
    logic [ADDR_W-1:0] ram_one_q;
    logic [ADDR_W-1:0] ram_two_q;
    // local RAM offsets
    // Bases are static levels, so these copies need no reset
    always_ff @(posedge clk_i) begin
        ram_one_q <= ADDR_W'(data_ram_base_i + `DAG_LOCAL_DATA_RAM_ONE_OFS);
        ram_two_q <= ADDR_W'(data_ram_base_i + `DAG_LOCAL_DATA_RAM_TWO_OFS);
    end
    assign ram_one_base_o = ram_one_q;
    assign ram_two_base_o = ram_two_q;
endmodule // dag_core

// File: src/dag_regs.svh
// Constants for the data address generator
`ifndef DAG_REGS_SVH
`define DAG_REGS_SVH
`define DAG_ADDR_W 32
`define DAG_LOCAL_DATA_RAM_ONE_OFS 32'h0000_0800
`define DAG_LOCAL_DATA_RAM_TWO_OFS 32'h0000_8000
`define DAG_SHORT_W 3
`define DAG_LONG_W 15
`define DAG_WORD_SHIFT 2
`define DAG_HALF_SHIFT 1
`define DAG_BYTE_SHIFT 0
`endif

// File: src/dag_pkg.sv
// Types for the data address generator
package dag_pkg;
    typedef enum logic [1:0] {DAG_SIZE_WORD, DAG_SIZE_HALF, DAG_SIZE_BYTE} dag_size_e;
    typedef enum logic [1:0] {DAG_BASE_REG, DAG_BASE_DATA, DAG_BASE_PARAM} dag_base_e;
    typedef enum logic [1:0] {DAG_XFER_SINGLE, DAG_XFER_LOCAL_MOVE, DAG_XFER_LOCAL_FIELD,
                              DAG_XFER_DUAL} dag_xfer_e;
    typedef struct packed {
        logic [31:0] reg_base;
        logic [31:0] index_reg;
        logic [15:0] imm;
        logic use_imm;
        logic long_imm;
        logic scale;
        logic subtract;
        logic post;
        logic modify;
        logic size_sel;
        dag_size_e size;
        logic unsigned_ld;
        dag_base_e base;
        dag_xfer_e xfer;
    } dag_req_s;
    typedef struct packed {
        logic [31:0] mem_addr;
        logic [31:0] wb_addr;
        logic wb_en;
        logic [3:0] byte_en;
    } dag_addr_s;
endpackage

// File: src/dag_extend.sv
// Load data lane selection and sign or zero extension
`timescale 1ns/1ns
module dag_extend (
    // Load data
    input wire logic [31:0] raw_i,
    input wire logic [1:0] lane_i,
    input wire dag_pkg::dag_size_e size_i,
    input wire logic unsigned_i,
    // Extended value
    output logic [31:0] ext_o
);
    wire [15:0] half_w = lane_i[1] ? raw_i[31:16] : raw_i[15:0];
    wire [7:0] byte_w = raw_i[8*lane_i +: 8];
    wire half_fill = ~unsigned_i & half_w[15];
    wire byte_fill = ~unsigned_i & byte_w[7];
    assign ext_o = (size_i == dag_pkg::DAG_SIZE_HALF) ? {{16{half_fill}}, half_w} :
                   (size_i == dag_pkg::DAG_SIZE_BYTE) ? {{24{byte_fill}}, byte_w} : raw_i;
endmodule // dag_extend

// File: sim/dag_core_properties.sv
// Checker for dag_core
`timescale 1ns/1ns
module dag_props (
    // Watched
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic req_valid_i,
    input wire dag_pkg::dag_req_s req_i,
    input wire logic addr_valid_o,
    input wire dag_pkg::dag_addr_s addr_o,
    input wire logic base_illegal_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    wire rq = req_valid_i && req_i.base == dag_pkg::DAG_BASE_REG;
    sequence s_one; req_valid_i ##1 !req_valid_i; endsequence
    property p_one; s_one |-> (addr_valid_o || base_illegal_o) ##1 !addr_valid_o; endproperty
    a_one: assert property (p_one) else $error("no answer");
    property p_idle; !req_valid_i |=> !addr_valid_o && !base_illegal_o; endproperty
    a_idle: assert property (p_idle) else $error("spurious answer");
    property p_bad; req_valid_i && !rq && req_i.xfer[1] |=>
        base_illegal_o && $stable(addr_o); endproperty
    a_bad: assert property (p_bad) else $error("local base kept");
    property p_word; rq && !req_i.size_sel |=> addr_o.mem_addr[1:0] == 2'h0; endproperty
    a_word: assert property (p_word) else $error("word unaligned");
    property p_half; rq && req_i.size_sel && req_i.size == dag_pkg::DAG_SIZE_HALF |=>
        !addr_o.mem_addr[0]; endproperty
    a_half: assert property (p_half) else $error("half unaligned");
    property p_wb; rq |=> addr_o.wb_en == ($past(req_i.post) || $past(req_i.modify)); endproperty
    a_wb: assert property (p_wb) else $error("write-back enable");
    property p_sum; rq && !req_i.use_imm && !req_i.scale && !req_i.subtract |=>
        addr_o.wb_addr == $past(req_i.reg_base) + $past(req_i.index_reg); endproperty
    a_sum: assert property (p_sum) else $error("sum wrong");
    property p_post; rq && req_i.post && !req_i.size_sel |=>
        addr_o.mem_addr == ($past(req_i.reg_base) & 32'hFFFF_FFFC); endproperty
    a_post: assert property (p_post) else $error("post address");
endmodule // dag_props
bind dag_core dag_props i_dag_props (.*);

// File: sim/dag_xbar.sv
// Crossbar model answering every access with one word
`timescale 1ns/1ns
module dag_xbar #(
    parameter int LAT = 1
) (
    // Address side
    input wire logic clk_i,
    input wire logic addr_valid_i,
    // Load side
    output logic load_valid_o,
    output logic [31:0] load_data_o
);
    logic [2:1] pend_q = 2'h0;
    always_ff @(posedge clk_i) pend_q <= {pend_q[1], addr_valid_i};
    assign load_valid_o = pend_q[LAT];
    // Idle bus shows the inverse so a stale word never passes
    assign load_data_o = load_valid_o ? 32'hF08C_7F01 : 32'h0F73_80FE;
endmodule // dag_xbar

// File: sim/tb_data_address_generator.sv
// Bench for the data address generator
`timescale 1ns/1ns
module tb_data_address_generator;
    typedef struct {logic [31:0] b, ma, wa, ex; logic [15:0] im; logic [7:0] f; logic lg;
        logic [3:0] be;} dag_row_s;
    logic clk_i = 1'b0, srst_i = 1'b1, req_valid_i = 1'b0;
    logic load_valid_i, addr_valid_o, base_illegal_o, ext_valid_o;
    logic [31:0] data_ram_base_i = 32'h0001_0000, param_ram_base_i = 32'h0002_0000;
    logic [31:0] load_data_i, ram_one_base_o, ram_two_base_o, ext_data_o;
    dag_pkg::dag_req_s req_i = '0;
    dag_pkg::dag_addr_s addr_o;
    int n_mismatch = 0, total_checks = 0;
    dag_row_s rows [6] = '{
        '{32'h1000, 32'h1000, 32'h0FF4, 32'hF08C_7F01, 16'h0, 8'h70, 1'b1, 4'hF},
        '{32'h0, 32'hA, 32'hA, 32'hFFFF_F08C, 16'h5, 8'hCA, 1'b1, 4'hC},
        '{32'h0, 32'h8002, 32'h8002, 32'h8C, 16'h2, 8'hCD, 1'b1, 4'h4},
        '{32'h100, 32'hF3, 32'hF3, 32'hFFFF_FFF0, 16'hFFFD, 8'hEC, 1'b0, 4'h8},
        '{32'h2001, 32'h2000, 32'h200F, 32'h7F01, 16'hF, 8'hDB, 1'b0, 4'h3},
        '{32'hFFFF_FFFE, 32'h0, 32'h1, 32'hF08C_7F01, 16'h0, 8'h00, 1'b1, 4'hF}};
    dag_core i_dag_core (.*);
    dag_xbar #(.LAT(2)) i_dag_xbar (.clk_i(clk_i), .addr_valid_i(addr_valid_o),
        .load_valid_o(load_valid_i), .load_data_o(load_data_i));
    initial forever #5 clk_i = ~clk_i;
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic send(input dag_pkg::dag_req_s r);
        req_i = r;
        req_valid_i = 1'b1;
        @(negedge clk_i);
    endtask
    task automatic test_done();
        $display("%0d mismatches in %0d checks", n_mismatch, total_checks);
        if (n_mismatch == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #2000;
        n_mismatch++;
        test_done();
    end
    initial begin
        dag_pkg::dag_req_s q;
        repeat (5) @(negedge clk_i);
        srst_i = 1'b0;
        foreach (rows[i]) begin
            send({rows[i].b, 32'h3, rows[i].im, rows[i].f[7], rows[i].lg, rows[i].f[6:4], 1'b0,
                rows[i].f[3:0], 4'h0});
            req_valid_i = 1'b0;
            chk("addr_valid_o", 32'(addr_valid_o), 32'h1);
            chk("mem_addr", addr_o.mem_addr, rows[i].ma);
            chk("wb_addr", addr_o.wb_addr, rows[i].wa);
            chk("byte_en", 32'(addr_o.byte_en), 32'(rows[i].be));
            repeat (3) @(negedge clk_i);
            chk("ext_valid_o", 32'(ext_valid_o), 32'h1);
            chk("ext_data_o", ext_data_o, rows[i].ex);
            $display("row %0d done", i);
        end
        // Back to back, every transfer kind on a local data base
        for (int x = 3; x >= 0; x--) begin
            send({80'h0, 7'h73, 2'h2, 3'h1, x[1:0]});
            chk("base_illegal_o", 32'(base_illegal_o), 32'(x > 1));
            chk("wb_addr", addr_o.wb_addr, x > 1 ? 32'h1 : 32'h0001_8000);
        end
        $display("local base done");
        // Parameter base straight after the last local request
        q = '0;
        q.index_reg = 32'h0000_0010;
        q.scale = 1'b1;
        q.subtract = 1'b1;
        q.modify = 1'b1;
        q.base = dag_pkg::DAG_BASE_PARAM;
        q.xfer = dag_pkg::DAG_XFER_LOCAL_MOVE;
        send(q);
        req_valid_i = 1'b0;
        chk("base_illegal_o", 32'(base_illegal_o), 32'h0);
        chk("wb_addr", addr_o.wb_addr, 32'h0001_FFC0);
        chk("mem_addr", addr_o.mem_addr, 32'h0001_FFC0);
        chk("ram_one_base_o", ram_one_base_o, 32'h0001_0800);
        chk("ram_two_base_o", ram_two_base_o, 32'h0001_8000);
        $display("parameter base done");
        // Reset in mid-run while loads are still returning
        srst_i = 1'b1;
        repeat (3) @(negedge clk_i);
        chk("addr_valid_o", 32'(addr_valid_o), 32'h0);
        chk("base_illegal_o", 32'(base_illegal_o), 32'h0);
        chk("wb_addr", addr_o.wb_addr, 32'h0);
        chk("ext_valid_o", 32'(ext_valid_o), 32'h0);
        chk("ext_data_o", ext_data_o, 32'h0);
        srst_i = 1'b0;
        send(q);
        req_valid_i = 1'b0;
        chk("addr_valid_o", 32'(addr_valid_o), 32'h1);
        chk("wb_addr", addr_o.wb_addr, 32'h0001_FFC0);
        chk("ext_valid_o", 32'(ext_valid_o), 32'h0);
        @(negedge clk_i);
        chk("addr_valid_o", 32'(addr_valid_o), 32'h0);
        chk("wb_addr", addr_o.wb_addr, 32'h0001_FFC0);
        $display("reset done");
        test_done();
    end
endmodule // tb_data_address_generator
